// [hw/mdio_indirect_extended_access.v]
// Serial management port with indirect extended-register access window
`timescale 1ns/1ps
`default_nettype none
`include "mdio_indirect_map.vh"

// Functional notes
// - Frame is idle, start, opcode, device address, register address, turnaround, 16 data, idle.
// - On an addressed read, float first turnaround bit, drive zero, then send data.
// - Five-bit register field indexes thirty-two directly addressable 16-bit registers.
// - Extended registers reached via access-control index 0x0D and window index 0x0E.
// - Registers 0 to 31 reachable directly; all but 0x0D and 0x0E also through the window.
// - Indirect accesses to 0x0D or 0x0E leave both registers unchanged; those respond to direct frames only.
// - Access-control bits 4:0 hold the device-select routing window accesses.
// - Only device-select value 11111 is implemented for extended accesses.
// - Window accesses with any other device-select value are ignored.
// - Bits 15:14 pick function: address, data, data inc read/write, data inc write.
// - Function 00: window write loads pointer, window read returns pointer.
// - Function 01: window reaches register at pointer, pointer unchanged.
// - Function 10: pointer increments after each completed window read and write.
// - Function 11: pointer increments after each completed window write.
// - Function 11: window read leaves pointer unchanged.
// - No-increment mode: repeated window writes overwrite the same extended register.
// - No-increment mode: repeated window reads return the same extended register.
module mdio_indirect_extended_access #(
  parameter PHY_ADDR_WIDTH = 5,
  parameter EXT_ADDR_BITS = 9
) (
  input wire clock,
  input wire reset_n,
  input wire mdc,
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe,
  input wire [PHY_ADDR_WIDTH-1:0] phy_address_strap,
  output wire [15:0] extended_pointer
);

  localparam S_IDLE = 3'd0;
  localparam S_START = 3'd1;
  localparam S_OP = 3'd2;
  localparam S_PHY = 3'd3;
  localparam S_REG = 3'd4;
  localparam S_TA = 3'd5;
  localparam S_DATA = 3'd6;
  localparam EXT_DEPTH = 1 << EXT_ADDR_BITS;

  // --------------------------------------------------------------------------
  // Input synchronisers and clock edge finder
  // --------------------------------------------------------------------------
  reg mdc_s1_reg;
  reg mdc_s2_reg;
  reg mdc_s3_reg;
  reg mdio_s1_reg;
  reg mdio_s2_reg;
  reg [PHY_ADDR_WIDTH-1:0] strap_s1_reg;
  reg [PHY_ADDR_WIDTH-1:0] strap_s2_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mdc_s1_reg <= 1'b0;
      mdc_s2_reg <= 1'b0;
      mdc_s3_reg <= 1'b0;
      mdio_s1_reg <= 1'b1;
      mdio_s2_reg <= 1'b1;
      strap_s1_reg <= {PHY_ADDR_WIDTH{1'b0}};
      strap_s2_reg <= {PHY_ADDR_WIDTH{1'b0}};
    end else begin
      mdc_s1_reg <= mdc;
      mdc_s2_reg <= mdc_s1_reg;
      mdc_s3_reg <= mdc_s2_reg;
      mdio_s1_reg <= mdio_in;
      mdio_s2_reg <= mdio_s1_reg;
      strap_s1_reg <= phy_address_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // Data and clock pass equal stages, so the sampled bit matches the edge
  wire mdc_rise = mdc_s2_reg & ~mdc_s3_reg;
  wire mdio_bit = mdio_s2_reg;

  // --------------------------------------------------------------------------
  // Address strap capture after reset release
  // --------------------------------------------------------------------------
  reg [1:0] strap_cnt_reg;
  reg [PHY_ADDR_WIDTH-1:0] phy_addr_reg;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strap_cnt_reg <= 2'h0;
      phy_addr_reg <= {PHY_ADDR_WIDTH{1'b0}};
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `STRAP_SETTLE) begin
        phy_addr_reg <= strap_s2_reg;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frame state
  // --------------------------------------------------------------------------
  reg [2:0] state_reg;
  reg [4:0] bit_cnt_reg;
  reg [15:0] shift_reg;
  reg [15:0] tx_reg;
  reg [1:0] op_reg;
  reg phy_hit_reg;
  reg [4:0] regad_reg;
  reg [15:0] ctrl_reg;
  reg [15:0] pointer_reg;

  wire [4:0] regad_next = {shift_reg[3:0], mdio_bit};
  wire [15:0] wdata = {shift_reg[14:0], mdio_bit};
  wire [1:0] func = ctrl_reg[`CTRL_FUNC_HI:`CTRL_FUNC_LO];
  wire dev_ok = ctrl_reg[`CTRL_DEVSEL_HI:`CTRL_DEVSEL_LO] == `DEVSEL_SUPPORTED;
  wire frame_end = mdc_rise && (state_reg == S_DATA) && (bit_cnt_reg == `DATA_BITS_LAST) && phy_hit_reg;
  wire wr_end = frame_end && (op_reg == `OP_WRITE);
  wire rd_end = frame_end && (op_reg == `OP_READ);
  // Other device-select values make the window inert both ways
  wire win_ok = (regad_reg == `IDX_EXT_ADDR_DATA_WINDOW) && dev_ok;
  wire win_data = win_ok && (func != `FUNC_ADDRESS);
  wire ptr_low = (pointer_reg[15:5] == 11'h000);
  // Window must not reach the two registers that steer it
  wire ptr_direct_ok = ptr_low && (pointer_reg[4:0] != `IDX_EXT_ACCESS_CONTROL) &&
                       (pointer_reg[4:0] != `IDX_EXT_ADDR_DATA_WINDOW);
  wire direct_frame = (regad_reg != `IDX_EXT_ACCESS_CONTROL) && (regad_reg != `IDX_EXT_ADDR_DATA_WINDOW);
  wire direct_we = wr_end && (direct_frame || (win_data && ptr_direct_ok));
  wire [4:0] direct_wa = direct_frame ? regad_reg : pointer_reg[4:0];
  wire ext_we = wr_end && win_data && !ptr_low;

  assign extended_pointer = pointer_reg;

  // --------------------------------------------------------------------------
  // Direct register words, one per index
  // --------------------------------------------------------------------------
  wire [15:0] direct_rd [0:31];
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_direct
      reg [15:0] word_reg;
      always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          word_reg <= `DIRECT_RESET;
        end else if (direct_we && (direct_wa == gi)) begin
          word_reg <= wdata;
        end
      end
      assign direct_rd[gi] = word_reg;
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Extended register storage
  // --------------------------------------------------------------------------
  // Pointer bits above EXT_ADDR_BITS alias onto the same words
  reg [15:0] ext_mem [0:EXT_DEPTH-1];

  always @(posedge clock) begin
    if (ext_we) begin
      ext_mem[pointer_reg[EXT_ADDR_BITS-1:0]] <= wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Read value chosen when the register field completes
  // --------------------------------------------------------------------------
  reg [15:0] read_value;

  always @* begin
    read_value = direct_rd[regad_next];
    if (regad_next == `IDX_EXT_ACCESS_CONTROL) begin
      read_value = ctrl_reg;
    end else if (regad_next == `IDX_EXT_ADDR_DATA_WINDOW) begin
      if (!dev_ok) begin
        read_value = `IGNORED_READ_VALUE;
      end else if (func == `FUNC_ADDRESS) begin
        read_value = pointer_reg;
      end else if (!ptr_low) begin
        read_value = ext_mem[pointer_reg[EXT_ADDR_BITS-1:0]];
      end else if (ptr_direct_ok) begin
        read_value = direct_rd[pointer_reg[4:0]];
      end else begin
        read_value = `IGNORED_READ_VALUE;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frame sequencer, control register and pointer
  // --------------------------------------------------------------------------
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      op_reg <= 2'h0;
      phy_hit_reg <= 1'b0;
      regad_reg <= 5'h00;
      ctrl_reg <= `CTRL_RESET;
      pointer_reg <= `POINTER_RESET;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      // Control takes effect at the end of its own frame, before any later frame
      if (wr_end && (regad_reg == `IDX_EXT_ACCESS_CONTROL)) begin
        ctrl_reg <= wdata;
      end
      if (wr_end && win_ok && (func == `FUNC_ADDRESS)) begin
        pointer_reg <= wdata;
      end else if (wr_end && win_data && (func[1] == 1'b1)) begin
        pointer_reg <= pointer_reg + 16'h0001;
      end else if (rd_end && win_ok && (func == `FUNC_DATA_INC_RW)) begin
        pointer_reg <= pointer_reg + 16'h0001;
      end
      if (mdc_rise) begin
        shift_reg <= wdata;
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        case (state_reg)
          S_IDLE: begin
            // First zero after idle ones opens the start pattern
            if (!mdio_bit) begin
              state_reg <= S_START;
            end
          end
          S_START: begin
            bit_cnt_reg <= 5'h00;
            state_reg <= mdio_bit ? S_OP : S_IDLE;
          end
          S_OP: begin
            if (bit_cnt_reg == `OP_BITS_LAST) begin
              op_reg <= wdata[1:0];
              bit_cnt_reg <= 5'h00;
              if ((wdata[1:0] == `OP_READ) || (wdata[1:0] == `OP_WRITE)) begin
                state_reg <= S_PHY;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_PHY: begin
            if (bit_cnt_reg == `ADDR_BITS_LAST) begin
              phy_hit_reg <= (wdata[PHY_ADDR_WIDTH-1:0] == phy_addr_reg);
              bit_cnt_reg <= 5'h00;
              state_reg <= S_REG;
            end
          end
          S_REG: begin
            if (bit_cnt_reg == `ADDR_BITS_LAST) begin
              regad_reg <= regad_next;
              tx_reg <= read_value;
              bit_cnt_reg <= 5'h00;
              state_reg <= S_TA;
            end
          end
          S_TA: begin
            // First turnaround bit stays floating, driving begins on the second
            if ((op_reg == `OP_READ) && phy_hit_reg) begin
              if (bit_cnt_reg == 5'h00) begin
                mdio_oe <= 1'b1;
                mdio_out <= 1'b0;
              end else begin
                mdio_out <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
              end
            end
            if (bit_cnt_reg == `TA_BITS_LAST) begin
              bit_cnt_reg <= 5'h00;
              state_reg <= S_DATA;
            end
          end
          S_DATA: begin
            if (bit_cnt_reg == `DATA_BITS_LAST) begin
              mdio_oe <= 1'b0;
              mdio_out <= 1'b0;
              bit_cnt_reg <= 5'h00;
              state_reg <= S_IDLE;
            end else if (mdio_oe) begin
              mdio_out <= tx_reg[15];
              tx_reg <= {tx_reg[14:0], 1'b0};
            end
          end
          default: begin
            state_reg <= S_IDLE;
            bit_cnt_reg <= 5'h00;
          end
        endcase
      end
    end
  end

endmodule // mdio_indirect_extended_access
`default_nettype wire

// [shared/mdio_indirect_map.vh]
// Register indexes, field positions, reset values and frame constants for the management port
`ifndef MDIO_INDIRECT_MAP_VH
`define MDIO_INDIRECT_MAP_VH

// ----------------------------------------------------------------------------
// Direct register indexes
// ----------------------------------------------------------------------------
`define IDX_EXT_ACCESS_CONTROL 5'h0D
`define IDX_EXT_ADDR_DATA_WINDOW 5'h0E

// ----------------------------------------------------------------------------
// Access-control fields
// ----------------------------------------------------------------------------
`define CTRL_FUNC_HI 15
`define CTRL_FUNC_LO 14
`define CTRL_DEVSEL_HI 4
`define CTRL_DEVSEL_LO 0
`define DEVSEL_SUPPORTED 5'h1F
`define FUNC_ADDRESS 2'h0
`define FUNC_DATA_NOINC 2'h1
`define FUNC_DATA_INC_RW 2'h2
`define FUNC_DATA_INC_WR 2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CTRL_RESET 16'h0000
`define POINTER_RESET 16'h0000
`define DIRECT_RESET 16'h0000
`define IGNORED_READ_VALUE 16'h0000

// ----------------------------------------------------------------------------
// Frame fields
// ----------------------------------------------------------------------------
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define OP_BITS_LAST 5'h01
`define ADDR_BITS_LAST 5'h04
`define TA_BITS_LAST 5'h01
`define DATA_BITS_LAST 5'h0F
`define STRAP_SETTLE 2'h2

`endif

// [tb/mdio_indirect_extended_access_sva.sv]
// Checker of device-side timing on the management port
`timescale 1ns/1ps
`default_nettype none
module mdio_port_checker #(
  parameter PHY_ADDR_WIDTH = 5,
  parameter EXT_ADDR_BITS = 9
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  input wire logic [PHY_ADDR_WIDTH-1:0] phy_address_strap,
  input wire logic [15:0] extended_pointer
);
  logic mdc_reg;
  logic [7:0] since_rise_reg;
  logic [4:0] drive_edges_reg;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mdc_reg <= 1'b0;
      since_rise_reg <= 8'hFF;
      drive_edges_reg <= 5'h00;
    end else begin
      mdc_reg <= mdc;
      // Saturate so a long idle never wraps back into the active window
      if (mdc && !mdc_reg) since_rise_reg <= 8'h00;
      else if (since_rise_reg != 8'hFF) since_rise_reg <= since_rise_reg + 8'h01;
      if (!mdio_oe) drive_edges_reg <= 5'h00;
      else if (mdc && !mdc_reg) drive_edges_reg <= drive_edges_reg + 5'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_RESET_QUIET: assert property ($rose(reset_n) |-> !mdio_oe && extended_pointer == 16'h0000)
    else $error("outputs not idle after reset");
  AST_TA_ZERO: assert property ($rose(mdio_oe) |-> !mdio_out [*8])
    else $error("second turnaround bit not zero");
  AST_DRIVE_HOLD: assert property ($rose(mdio_oe) |=> mdio_oe [*8])
    else $error("drive dropped inside a bit");
  AST_DRIVE_LAUNCH: assert property ($rose(mdio_oe) |-> since_rise_reg <= 8'd10)
    else $error("drive began away from a clock edge");
  AST_OUT_LAUNCH: assert property ($changed(mdio_out) |-> since_rise_reg <= 8'd10)
    else $error("data bit changed away from a clock edge");
  AST_DRIVE_SPAN: assert property ($fell(mdio_oe) |-> drive_edges_reg == 5'd17)
    else $error("drive span not turnaround plus sixteen bits");
  AST_PTR_LAUNCH: assert property ($changed(extended_pointer) |-> since_rise_reg <= 8'd10)
    else $error("pointer moved outside a frame edge");
  AST_IDLE_SILENT: assert property (since_rise_reg > 8'd40 |-> !mdio_oe)
    else $error("line driven while the bus is idle");
endmodule // mdio_port_checker
bind mdio_indirect_extended_access mdio_port_checker #(.PHY_ADDR_WIDTH(PHY_ADDR_WIDTH),
  .EXT_ADDR_BITS(EXT_ADDR_BITS)) checker_inst (.clock, .reset_n, .mdc, .mdio_in, .mdio_out,
  .mdio_oe, .phy_address_strap, .extended_pointer);
`default_nettype wire

// [tb/station_manager_model.sv]
// Station manager model that clocks and drives management frames
`timescale 1ns/1ps
`default_nettype none
module station_manager_model (
  input wire logic clock,
  input wire logic mdio_line,
  output logic mdc,
  output logic mdio_drive,
  output logic mdio_drive_en
);
  logic ta_first;
  logic ta_second;
  // Forces an undefined opcode so the frame must be dropped
  logic op_bad = 1'b0;
  initial begin
    mdc = 1'b0;
    mdio_drive = 1'b1;
    mdio_drive_en = 1'b0;
  end
  task automatic half_bit();
    repeat (8) @(negedge clock);
  endtask
  // Clock stands still low between frames; line released to the pull-up
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [33:0] bits;
    int i;
    bits = {4'b1101, op_bad ? 2'b00 : (rd ? 2'b10 : 2'b01), pa, ra, 2'b10, wd};
    for (i = 33; i >= 0; i--) begin
      mdio_drive_en = !(rd && i < 18);
      mdio_drive = bits[i];
      half_bit();
      if (i == 17) ta_first = mdio_line;
      if (i == 16) ta_second = mdio_line;
      q = {q[14:0], mdio_line};
      mdc = 1'b1;
      half_bit();
      mdc = 1'b0;
    end
    // Idle gap keeps the release apart from the next frame's first drive
    mdio_drive_en = 1'b0;
    half_bit();
  endtask
endmodule // station_manager_model
`default_nettype wire

// [tb/mdio_indirect_extended_access_bench.sv]
// Self-checking bench for the indirect extended-register window
`timescale 1ns/1ps
`default_nettype none
`include "mdio_indirect_map.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mdio_indirect_extended_access_bench;
  localparam logic [4:0] PA = 5'h05;
  localparam logic [4:0] C = `IDX_EXT_ACCESS_CONTROL;
  localparam logic [4:0] W = `IDX_EXT_ADDR_DATA_WINDOW;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic mdc, st_drv, st_en, dut_out, dut_oe, mdio_line;
  logic [15:0] ptr, q;
  int n_fail = 0;
  int checked = 0;
  always #2.5 clock = ~clock;
  // Pull-up wins whenever neither side drives
  assign mdio_line = dut_oe ? dut_out : (st_en ? st_drv : 1'b1);
  mdio_indirect_extended_access #(.PHY_ADDR_WIDTH(5), .EXT_ADDR_BITS(9)) dut (.clock(clock),
    .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(dut_out), .mdio_oe(dut_oe),
    .phy_address_strap(PA), .extended_pointer(ptr));
  station_manager_model station (.clock(clock), .mdio_line(mdio_line), .mdc(mdc),
    .mdio_drive(st_drv), .mdio_drive_en(st_en));
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] unused;
    station.frame(1'b0, PA, ra, d, unused);
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e, input string n);
    logic [15:0] v;
    station.frame(1'b1, PA, ra, 16'h0000, v);
    `CHK(n, e, v)
    `CHK("ta float", 1'b1, station.ta_first)
    `CHK("ta zero", 1'b0, station.ta_second)
  endtask
  task automatic setp(input logic [15:0] p);
    wr(C, 16'h001F);
    wr(W, p);
  endtask
  task automatic chp(input logic [15:0] e);
    `CHK("pointer", e, ptr)
  endtask
  task automatic give_verdict();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    repeat (20) @(negedge clock);
    chp(16'h0000);
    wr(5'h03, 16'hA5C3);
    rd(5'h03, 16'hA5C3, "direct 3");
    wr(5'h1F, 16'h5A3C);
    rd(5'h1F, 16'h5A3C, "direct 31");
    station.frame(1'b0, 5'h06, 5'h03, 16'h0000, q);
    station.frame(1'b1, 5'h06, 5'h03, 16'h0000, q);
    `CHK("foreign read", 16'hFFFF, q)
    rd(5'h03, 16'hA5C3, "foreign write");
    station.op_bad = 1'b1;
    station.frame(1'b0, PA, 5'h1F, 16'hFFFF, q);
    station.op_bad = 1'b0;
    rd(5'h1F, 16'h5A3C, "bad opcode");
    setp(16'h0170);
    chp(16'h0170);
    wr(W, 16'h0171);
    chp(16'h0171);
    rd(W, 16'h0171, "pointer read");
    wr(C, 16'h401F);
    wr(W, 16'h0C50);
    wr(W, 16'h1234);
    chp(16'h0171);
    rd(W, 16'h1234, "noinc read");
    rd(W, 16'h1234, "noinc reread");
    chp(16'h0171);
    wr(C, 16'h801F);
    wr(W, 16'hAAAA);
    wr(W, 16'hBBBB);
    chp(16'h0173);
    setp(16'h0171);
    wr(C, 16'h801F);
    rd(W, 16'hAAAA, "inc read 1");
    rd(W, 16'hBBBB, "inc read 2");
    chp(16'h0173);
    setp(16'h0174);
    wr(C, 16'hC01F);
    wr(W, 16'hDDDD);
    chp(16'h0175);
    setp(16'h0174);
    wr(C, 16'hC01F);
    rd(W, 16'hDDDD, "wronly read");
    chp(16'h0174);
    wr(C, 16'h401E);
    rd(W, 16'h0000, "other device");
    wr(W, 16'h9999);
    chp(16'h0174);
    wr(C, 16'h401F);
    rd(W, 16'hDDDD, "ignored write");
    setp(16'h0003);
    wr(C, 16'h401F);
    rd(W, 16'hA5C3, "window direct");
    wr(W, 16'h1111);
    rd(5'h03, 16'h1111, "direct via window");
    setp(16'h000D);
    wr(C, 16'h401F);
    wr(W, 16'hFFFF);
    rd(C, 16'h401F, "control kept");
    rd(W, 16'h0000, "window self");
    // Mid-run reset must clear control, pointer and direct words
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    repeat (20) @(negedge clock);
    chp(16'h0000);
    rd(C, 16'h0000, "control after reset");
    rd(5'h03, 16'h0000, "direct after reset");
    give_verdict();
  end
endmodule // mdio_indirect_extended_access_bench
`default_nettype wire
